//--- dv/ifsb_event_src.sv
// event source model: registers bench requests into event pulses one cycle later
module ifsb_event_src (
  input  wire logic                  clock,  // system clock
  input  wire logic                  rst_n,  // async reset, active low
  input  wire ifsb_pkg::ifsb_flags_t fire,   // bench request per source
  output ifsb_pkg::ifsb_flags_t      evt     // pulses, flagsOut bit order
);
  import ifsb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  ifsb_flags_t evt_r;    // registered pulses
  ifsb_flags_t evt_nxt;  // next pulses
  // a source strobes for as long as the bench holds fire, with no edge detection
  always_comb begin
    evt_nxt = fire;
  end
  // launched from the clock edge, so the bank sees clean pulses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= '0;
    end else begin
      evt_r <= evt_nxt;
    end
  end
  assign evt = evt_r;
endmodule : ifsb_event_src

//--- dv/ifsb_flag_bank_tb.sv
// self-checking bench for the interrupt flag status bank
`include "ifsb_map.svh"
module ifsb_flag_bank_tb;
  import ifsb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {ifsb_addr_t a; ifsb_word_t w;} ifsb_row_t;  // one case
  logic        clock, rst_n;          // clock and reset
  ifsb_addr_t  regAddr;               // bus address
  ifsb_word_t  regWrData, regRdData;  // bus data
  logic        regWrStb, regRdStb;    // bus strobes
  ifsb_flags_t fire, evt, flagsOut;   // requests, pulses, flags
  logic        irqOut;                // interrupt level
  int          errTotal = 0;          // mismatches
  int          testsRun = 0;          // comparisons
  // register and bit of each source, in flagsOut order
  ifsb_row_t rows[9] = '{'{4'h0, 16'h0002}, '{4'h0, 16'h0001},
    '{4'h4, 16'h8000}, '{4'h4, 16'h4000}, '{4'h4, 16'h0200},
    '{4'h4, 16'h0100}, '{4'h4, 16'h0080}, '{4'h4, 16'h0002},
    '{4'h4, 16'h0001}};
  ifsb_flag_bank ifsb_flag_bank_inst (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .capOneEvt(evt[0]), .extZeroEvt(evt[1]),
    .pairOneEvt(evt[2]), .pairZeroEvt(evt[3]), .cmpFourEvt(evt[4]),
    .cmpThreeEvt(evt[5]), .cmpTwoEvt(evt[6]), .pgFourEvt(evt[7]),
    .pgThreeEvt(evt[8]), .regRdData(regRdData), .flagsOut(flagsOut),
    .irqOut(irqOut));
  ifsb_event_src ifsb_event_src_inst (.clock(clock), .rst_n(rst_n),
    .fire(fire), .evt(evt));
  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // word compare
  task automatic chk(input string n, input ifsb_word_t e, ifsb_word_t g);
    testsRun++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  // single bit compare, kept apart so an unknown level is caught
  task automatic chkBit(input string n, input logic e, input logic g);
    testsRun++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask : chkBit
  // one-cycle write
  task automatic wr(input ifsb_addr_t a, input ifsb_word_t d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask : wr
  // read, data stands only in the cycle after the strobe
  task automatic rdChk(input string n, input ifsb_addr_t a, ifsb_word_t e);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1 chk(n, e, regRdData);
  endtask : rdChk
  // fire events; three edges let the flag land
  task automatic pulse(input ifsb_flags_t m);
    @(posedge clock);
    fire <= m;
    @(posedge clock);
    fire <= '0;
    repeat (2) @(posedge clock);
  endtask : pulse
  task automatic finishTest;
    $display("comparisons %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finishTest
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    finishTest();
  end
  initial begin
    rst_n = 1'b0;
    {regAddr, regWrData, regWrStb, regRdStb, fire} = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    // each source sets only its own bit, which stays, then clears
    for (int i = 0; i < 9; i++) begin
      pulse(9'h1 << i);
      rdChk("flag", rows[i].a, rows[i].w);
      rdChk("flag again", rows[i].a, rows[i].w);
      rdChk("other", rows[i].a ^ 4'h4, 16'h0000);
      chk("flagsOut", 16'(9'h1 << i), 16'(flagsOut));
      rdChk("status", 4'h8, 16'(9'h1 << i));
      wr(rows[i].a, 16'h0000);
      wr(4'h6, 16'h01ff);
      rdChk("cleared", rows[i].a, 16'h0000);
      rdChk("status cleared", 4'h8, 16'h0000);
    end
    $display("test sources done");
    // reserved bits and unmapped place ignore writes
    wr(4'h0, 16'hffff);
    wr(4'h4, 16'hffff);
    rdChk("zero mask", 4'h0, 16'h0003);
    rdChk("six mask", 4'h4, 16'hc383);
    wr(4'h2, 16'hffff);
    rdChk("unmapped", 4'h2, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'h0000);
    rdChk("six off", 4'h4, 16'h0000);
    $display("test reserved done");
    // event wins over a write of zero in the same cycle
    @(posedge clock);
    fire <= 9'h004;
    @(posedge clock);
    fire <= '0;
    regAddr <= 4'h4;
    regWrData <= 16'h0000;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
    rdChk("event wins", 4'h4, 16'h8000);
    wr(4'h6, 16'h01ff);
    $display("test collision done");
    // interrupt: raised only when enabled, masked, cleared
    wr(4'hc, 16'h0004);
    rdChk("enable", 4'hc, 16'h0004);
    pulse(9'h008);
    chkBit("irq masked", 1'b0, irqOut);
    pulse(9'h004);
    chkBit("irq on", 1'b1, irqOut);
    wr(4'hc, 16'h0000);
    @(posedge clock);
    chkBit("irq off", 1'b0, irqOut);
    wr(4'hc, 16'h0004);
    @(posedge clock);
    chkBit("irq back", 1'b1, irqOut);
    wr(4'h6, 16'h0004);
    @(posedge clock);
    chkBit("irq cleared", 1'b0, irqOut);
    $display("test interrupt done");
    // reset in mid-run clears everything
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rdChk("six reset", 4'h4, 16'h0000);
    rdChk("zero reset", 4'h0, 16'h0000);
    rdChk("enable reset", 4'hc, 16'h0000);
    chkBit("irq reset", 1'b0, irqOut);
    $display("test reset done");
    finishTest();
  end
endmodule : ifsb_flag_bank_tb

//--- hw/ifsb_flag_bank.sv
// interrupt flag status bank: flag registers zero and six, irq status
`include "ifsb_map.svh"
module ifsb_flag_bank (
  input  wire logic               clock,             // 125 MHz clock
  input  wire logic               rst_n,             // async reset
  input  wire ifsb_pkg::ifsb_addr_t regAddr,          // register offset
  input  wire ifsb_pkg::ifsb_word_t regWrData,        // write data
  input  wire logic               regWrStb,          // write strobe
  input  wire logic               regRdStb,          // read strobe
  input  wire logic               capOneEvt,         // capture one request
  input  wire logic               extZeroEvt,        // ext line zero request
  input  wire logic               pairOneEvt,        // pair one done
  input  wire logic               pairZeroEvt,       // pair zero done
  input  wire logic               cmpFourEvt,        // comparator four
  input  wire logic               cmpThreeEvt,       // comparator three
  input  wire logic               cmpTwoEvt,         // comparator two
  input  wire logic               pgFourEvt,         // pulse gen four
  input  wire logic               pgThreeEvt,        // pulse gen three
  output ifsb_pkg::ifsb_word_t    regRdData,         // read data, next cycle
  output ifsb_pkg::ifsb_flags_t   flagsOut,          // flags to priority logic
  output logic                    irqOut             // level interrupt
);
  import ifsb_pkg::*;

  ifsb_flags_t evtVec;     // event inputs as a vector
  ifsb_flags_t wrEnVec;    // per-flag software write enable
  ifsb_flags_t wrValVec;   // per-flag software write value
  ifsb_flags_t flagVec;    // flag cell outputs
  ifsb_word_t  zeroWord;   // flag register zero as read
  ifsb_word_t  sixWord;    // flag register six as read
  logic wrZero;            // write hits register zero
  logic wrSix;             // write hits register six

  // events are on-chip, same clock: no synchroniser needed
  assign evtVec = {pgThreeEvt, pgFourEvt, cmpTwoEvt, cmpThreeEvt,
                   cmpFourEvt, pairZeroEvt, pairOneEvt, extZeroEvt,
                   capOneEvt};

  assign wrZero = regWrStb && (regAddr == `IFSB_OFF_FLAGS_ZERO);
  assign wrSix  = regWrStb && (regAddr == `IFSB_OFF_FLAGS_SIX);

  // map writable bit positions onto the flag cells
  always_comb begin
    wrEnVec  = '0;
    wrValVec = '0;
    wrEnVec[`IFSB_BIT_CAP_ONE]   = wrZero;
    wrValVec[`IFSB_BIT_CAP_ONE]  = regWrData[1];
    wrEnVec[`IFSB_BIT_EXT_ZERO]  = wrZero;
    wrValVec[`IFSB_BIT_EXT_ZERO] = regWrData[0];
    wrEnVec[`IFSB_BIT_PAIR_ONE]  = wrSix;
    wrValVec[`IFSB_BIT_PAIR_ONE] = regWrData[15];
    wrEnVec[`IFSB_BIT_PAIR_ZERO] = wrSix;
    wrValVec[`IFSB_BIT_PAIR_ZERO] = regWrData[14];
    wrEnVec[`IFSB_BIT_CMP_FOUR]  = wrSix;
    wrValVec[`IFSB_BIT_CMP_FOUR] = regWrData[9];
    wrEnVec[`IFSB_BIT_CMP_THREE] = wrSix;
    wrValVec[`IFSB_BIT_CMP_THREE] = regWrData[8];
    wrEnVec[`IFSB_BIT_CMP_TWO]   = wrSix;
    wrValVec[`IFSB_BIT_CMP_TWO]  = regWrData[7];
    wrEnVec[`IFSB_BIT_PG_FOUR]   = wrSix;
    wrValVec[`IFSB_BIT_PG_FOUR]  = regWrData[1];
    wrEnVec[`IFSB_BIT_PG_THREE]  = wrSix;
    wrValVec[`IFSB_BIT_PG_THREE] = regWrData[0];
  end

  // one sticky cell per flag
  genvar gi;
  generate
    for (gi = 0; gi < `IFSB_NUM_FLAGS; gi++) begin : g_flag
      ifsb_flag_cell u_cell (
        .clock   (clock),
        .rst_n   (rst_n),
        .eventIn (evtVec[gi]),
        .wrEn    (wrEnVec[gi]),
        .wrVal   (wrValVec[gi]),
        .flag    (flagVec[gi])
      );
    end
  endgenerate

  // assemble read words; unimplemented positions are hard zero
  always_comb begin
    zeroWord = `IFSB_RESET_VAL;
    sixWord  = `IFSB_RESET_VAL;
    zeroWord[1]  = flagVec[`IFSB_BIT_CAP_ONE];
    zeroWord[0]  = flagVec[`IFSB_BIT_EXT_ZERO];
    sixWord[15]  = flagVec[`IFSB_BIT_PAIR_ONE];
    sixWord[14]  = flagVec[`IFSB_BIT_PAIR_ZERO];
    sixWord[9]   = flagVec[`IFSB_BIT_CMP_FOUR];
    sixWord[8]   = flagVec[`IFSB_BIT_CMP_THREE];
    sixWord[7]   = flagVec[`IFSB_BIT_CMP_TWO];
    sixWord[1]   = flagVec[`IFSB_BIT_PG_FOUR];
    sixWord[0]   = flagVec[`IFSB_BIT_PG_THREE];
  end

  // interrupt status / enable, same 9-bit layout as flagVec
  ifsb_flags_t irqStat_r;    // sticky irq status
  ifsb_flags_t irqStat_nxt;
  ifsb_flags_t irqEn_r;      // irq enable mask
  ifsb_flags_t irqEn_nxt;
  logic        irq_r;        // registered interrupt line
  logic        irq_nxt;

  // status set by events beats a clear in the same cycle
  always_comb begin
    irqStat_nxt = irqStat_r;
    irqEn_nxt   = irqEn_r;
    if (regWrStb && regAddr == `IFSB_OFF_IRQ_CLR) begin
      irqStat_nxt = irqStat_r & ~regWrData[8:0];
    end
    if (regWrStb && regAddr == `IFSB_OFF_IRQ_EN) begin
      irqEn_nxt = regWrData[8:0];
    end
    irqStat_nxt = irqStat_nxt | evtVec;
    irq_nxt     = |(irqStat_nxt & irqEn_nxt);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= '0;
      irqEn_r   <= '0;
      irq_r     <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irqEn_r   <= irqEn_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // read path: data valid one cycle after the strobe, else zero
  ifsb_word_t  rdData_r;
  ifsb_word_t  rdData_nxt;
  ifsb_flags_t flagsOut_r;

  always_comb begin
    rdData_nxt = '0;
    if (regRdStb) begin
      unique case (regAddr)
        `IFSB_OFF_FLAGS_ZERO: rdData_nxt = zeroWord;
        `IFSB_OFF_FLAGS_SIX:  rdData_nxt = sixWord;
        `IFSB_OFF_IRQ_STAT:   rdData_nxt = {7'h00, irqStat_r};
        `IFSB_OFF_IRQ_EN:     rdData_nxt = {7'h00, irqEn_r};
        default:              rdData_nxt = '0;  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r   <= '0;
      flagsOut_r <= '0;
    end else begin
      rdData_r   <= rdData_nxt;
      flagsOut_r <= flagVec;  // one cycle late, keeps output registered
    end
  end

  assign regRdData = rdData_r;
  assign flagsOut  = flagsOut_r;
  assign irqOut    = irq_r;

  // reserved positions of register six never read as one
  property p_unimpl_zero;
    @(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_FLAGS_SIX |=>
      (regRdData & ~`IFSB_SIX_MASK) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("reserved bit of reg six read nonzero");
  // reserved positions of register zero never read as one
  property p_zero_reserved;
    @(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_FLAGS_ZERO |=>
      (regRdData & ~`IFSB_ZERO_MASK) == 16'h0000;
  endproperty
  a_zero_reserved: assert property (p_zero_reserved)
    else $error("reserved bit of reg zero read nonzero");
  // each event shows in its read word one cycle later
  property p_pair_one;
    @(posedge clock) disable iff (!rst_n)
    pairOneEvt |=> sixWord[15];
  endproperty
  a_pair_one: assert property (p_pair_one)
    else $error("pair one flag not set");
  property p_pair_zero;
    @(posedge clock) disable iff (!rst_n)
    pairZeroEvt |=> sixWord[14];
  endproperty
  a_pair_zero: assert property (p_pair_zero)
    else $error("pair zero flag not set");
  property p_cap_one;
    @(posedge clock) disable iff (!rst_n)
    capOneEvt |=> zeroWord[1];
  endproperty
  a_cap_one: assert property (p_cap_one)
    else $error("capture one flag not set");
  property p_ext_zero;
    @(posedge clock) disable iff (!rst_n)
    extZeroEvt |=> zeroWord[0];
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("ext line zero flag not set");
  // comparator and pulse gen flags sit at their own positions
  property p_cmp_four;
    @(posedge clock) disable iff (!rst_n)
    cmpFourEvt |=> sixWord[9];
  endproperty
  a_cmp_four: assert property (p_cmp_four)
    else $error("comparator four flag not set");
  property p_cmp_three;
    @(posedge clock) disable iff (!rst_n)
    cmpThreeEvt |=> sixWord[8];
  endproperty
  a_cmp_three: assert property (p_cmp_three)
    else $error("comparator three flag not set");
  property p_cmp_two;
    @(posedge clock) disable iff (!rst_n)
    cmpTwoEvt |=> sixWord[7];
  endproperty
  a_cmp_two: assert property (p_cmp_two)
    else $error("comparator two flag not set");
  property p_pg_four;
    @(posedge clock) disable iff (!rst_n)
    pgFourEvt |=> sixWord[1];
  endproperty
  a_pg_four: assert property (p_pg_four)
    else $error("pulse gen four flag not set");
  property p_pg_three;
    @(posedge clock) disable iff (!rst_n)
    pgThreeEvt |=> sixWord[0];
  endproperty
  a_pg_three: assert property (p_pg_three)
    else $error("pulse gen three flag not set");
  // the read word carries the flags as they stood at the strobe
  property p_rd_six;
    @(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_FLAGS_SIX |=>
      regRdData == $past(sixWord);
  endproperty
  a_rd_six: assert property (p_rd_six)
    else $error("reg six read data wrong");
  property p_rd_zero;
    @(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_FLAGS_ZERO |=>
      regRdData == $past(zeroWord);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("reg zero read data wrong");
  // outside a read answer the data lines rest at zero
  property p_rd_idle;
    @(posedge clock) disable iff (!rst_n)
    !regRdStb |=> regRdData == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero when idle");
  // status and enable read back what they held
  property p_stat_rd;
    @(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_IRQ_STAT |=>
      regRdData == {7'h00, $past(irqStat_r)};
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("status read data wrong");
  property p_en_rd;
    @(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_IRQ_EN |=>
      regRdData == {7'h00, $past(irqEn_r)};
  endproperty
  a_en_rd: assert property (p_en_rd)
    else $error("enable read data wrong");
  // any enabled event raises the line unless the enable is rewritten that cycle, a clear cannot beat it
  property p_irq_follows;
    @(posedge clock) disable iff (!rst_n)
    ((|(evtVec & irqEn_r))
      && !(regWrStb && regAddr == `IFSB_OFF_IRQ_EN)) |=> irqOut;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("enabled event gave no interrupt");
  // with every source masked the line stays low
  property p_irq_off;
    @(posedge clock) disable iff (!rst_n)
    (irqEn_r == 9'h000 && !(regWrStb && regAddr == `IFSB_OFF_IRQ_EN))
      |=> !irqOut;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("masked interrupt raised");
  // flag copy toward priority logic lags the cells by one cycle
  property p_flags_out;
    @(posedge clock) disable iff (!rst_n)
    1'b1 |=> flagsOut == $past(flagVec);
  endproperty
  a_flags_out: assert property (p_flags_out)
    else $error("flag copy does not follow cells");
  // a software clear with no event in that cycle leaves zero
  property p_clear_reads_zero;
    @(posedge clock) disable iff (!rst_n)
    (wrZero && regWrData[0] == 1'b0 && !extZeroEvt) |=> !zeroWord[0];
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("cleared flag read one");
  c_irq: cover property (@(posedge clock) disable iff (!rst_n) irqOut);
  c_rd_six: cover property (@(posedge clock) disable iff (!rst_n)
    regRdStb && regAddr == `IFSB_OFF_FLAGS_SIX);
  c_set_clr: cover property (@(posedge clock) disable iff (!rst_n)
    wrSix && pairOneEvt);
  c_irq_clear: cover property (@(posedge clock) disable iff (!rst_n)
    regWrStb && regAddr == `IFSB_OFF_IRQ_CLR && irqOut);
  c_wr_zero: cover property (@(posedge clock) disable iff (!rst_n)
    wrZero && regWrData[1:0] == 2'h3);
endmodule : ifsb_flag_bank

//--- hw/ifsb_flag_cell.sv
// one sticky flag bit: set by its event, written or cleared by software
module ifsb_flag_cell (
  input  wire logic clock,    // system clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic eventIn,  // one-cycle request from the source
  input  wire logic wrEn,     // software writes this bit
  input  wire logic wrVal,    // value software writes
  output logic      flag      // stored flag
);
  logic flag_r;    // flag storage
  logic flag_nxt;  // next flag value

  // an event in the same cycle as a software clear wins, so nothing is lost
  always_comb begin
    flag_nxt = flag_r;
    if (wrEn) begin
      flag_nxt = wrVal;
    end
    if (eventIn) begin
      flag_nxt = 1'b1;
    end
  end

  // register only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

  // an event always leaves the flag set one cycle later
  property p_event_sets;
    @(posedge clock) disable iff (!rst_n)
    eventIn |=> flag_r;
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event did not set flag");
  // a clear with no event in the same cycle reads back as zero
  property p_clear_holds;
    @(posedge clock) disable iff (!rst_n)
    (wrEn && !wrVal && !eventIn) |=> !flag_r;
  endproperty
  a_clear_holds: assert property (p_clear_holds)
    else $error("software clear lost");
endmodule : ifsb_flag_cell

//--- shared/ifsb_map.svh
// register offsets, field positions and reset values of the flag bank
// Summary of operation
// - source event sets its flag bit to one
// - idle or cleared flag reads as zero
// - reg six bit 15: pair one done
// - reg six bit 14: pair zero done
// - reg zero bit 1: capture one flag
// - reg zero bit 0: external line zero
// - unimplemented bits ignore writes, read zero
`ifndef IFSB_MAP_SVH
`define IFSB_MAP_SVH
`define IFSB_OFF_FLAGS_ZERO 4'h0
`define IFSB_OFF_FLAGS_SIX  4'h4
`define IFSB_OFF_IRQ_STAT   4'h8
`define IFSB_OFF_IRQ_EN     4'hc
`define IFSB_OFF_IRQ_CLR    4'h6
`define IFSB_BIT_CAP_ONE    0
`define IFSB_BIT_EXT_ZERO   1
`define IFSB_BIT_PAIR_ONE   2
`define IFSB_BIT_PAIR_ZERO  3
`define IFSB_BIT_CMP_FOUR   4
`define IFSB_BIT_CMP_THREE  5
`define IFSB_BIT_CMP_TWO    6
`define IFSB_BIT_PG_FOUR    7
`define IFSB_BIT_PG_THREE   8
`define IFSB_NUM_FLAGS      9
`define IFSB_ZERO_MASK      16'h0003
`define IFSB_SIX_MASK       16'hc383
`define IFSB_RESET_VAL      16'h0000
`endif

//--- shared/ifsb_pkg.sv
// types shared by the flag bank files
package ifsb_pkg;
  typedef logic [15:0] ifsb_word_t;   // one register word
  typedef logic [3:0]  ifsb_addr_t;   // register offset
  typedef logic [8:0]  ifsb_flags_t;  // one bit per event source
endpackage : ifsb_pkg
